// ===== hdl/srxal_top.sv
// Receive lock control, deserializer, word aligner and APB register slave
`timescale 1ns/1ns
module srxal_top (
  input  wire logic        SYS_CLK,        // System clock, 50 MHz
  input  wire logic        SYS_RST,        // Synchronous reset, active high
  input  wire logic        PSEL,           // APB select
  input  wire logic        PENABLE,        // APB enable
  input  wire logic        PWRITE,         // APB write
  input  wire logic [7:0]  PADDR,          // APB byte address
  input  wire logic [31:0] PWDATA,         // APB write data
  output logic      [31:0] PRDATA,         // APB read data
  output logic             PREADY,         // APB ready
  output logic             PSLVERR,        // APB error, unmapped address
  input  wire logic        SER_IN,         // Recovered serial bit
  input  wire logic        SER_VALID,      // Serial bit present this cycle
  input  wire logic        PLL_REF_LOCK,   // Receiver PLL locked to reference
  input  wire logic [10:0] CRU_PPM_ERR,    // Frequency error magnitude, PPM
  input  wire logic [7:0]  CRU_PHASE_ERR,  // Phase error, hundredths of a UI
  output logic      [19:0] DATA_OUT,       // Aligned word or word pair
  output logic             DATA_VALID,     // Pulse with DATA_OUT
  output logic             ALIGNED,        // Boundary acquired
  output logic             PATTERN_DET,    // Pulse on pattern seen
  output logic             RUN_VIOL,       // Sticky run-length violation
  output logic             FREQ_LOCKED,    // Recovery unit locked to data
  output logic             RX_LOCKED_N,    // PLL locked to reference, low active
  output logic             CRU_PWR_DN,     // PLL and recovery unit power-down
  output logic             CRU_TRAIN_DATA  // Oscillator trained by data
);

  // ==========================================================================
  // State
  srxal_pkg::srxal_st_t s_r;
  srxal_pkg::srxal_st_t s_nxt;

  logic        bit_v;
  logic [31:0] hist_new;
  logic [9:0]  last10;
  logic [9:0]  pat10;
  logic [3:0]  wbits;
  logic        on_bnd;
  logic        hit10;
  logic        hit16;
  logic        hit;
  logic        mode_ok;
  logic        allow;
  logic        take_align;
  logic        hold;
  logic [9:0]  word;
  logic [5:0]  stp;
  logic [7:0]  rl_limit;
  logic [10:0] ppm_thr;
  logic        setup;
  logic        access;
  logic        unmapped;
  logic [31:0] rd_mux;

  // ==========================================================================
  // Data path helpers
  assign bit_v    = SER_VALID & s_r.ctrl.chan_en;
  // Oldest bit sits lowest so a word's first bit is its LSB
  assign hist_new = {SER_IN, s_r.hist[31:1]}; // [R9]
  assign last10   = hist_new[31:22];
  assign wbits    = s_r.ctrl.w10 ? 4'd10 : 4'd8; // [R8]
  assign on_bnd   = (s_r.bcnt == (wbits - 4'd1));
  assign word     = s_r.ctrl.w10 ? last10 : {2'b00, hist_new[31:24]};

  assign pat10 = (s_r.ctrl.mode == srxal_pkg::AM_XAUI || s_r.ctrl.mode == srxal_pkg::AM_GIGE)
               ? srxal_pkg::K28_RDN : s_r.pat[9:0]; // [R21]

  // Both disparities: the other running disparity is the bitwise complement
  always_comb begin
    if (s_r.ctrl.mode == srxal_pkg::AM_10 && s_r.ctrl.match7) begin // [R18]
      hit10 = (last10[6:0] == pat10[6:0]) || (last10[6:0] == ~pat10[6:0]); // [R19]
    end else begin
      hit10 = (last10 == pat10) || (last10 == ~pat10); // [R19]
    end
  end

  always_comb begin
    if (s_r.ctrl.fmt4) begin // [R14]
      hit16 = (hist_new == {s_r.pat[15:8], s_r.pat[15:8], s_r.pat[7:0], s_r.pat[7:0]});
    end else begin
      hit16 = (hist_new[31:16] == s_r.pat[15:0]);
    end
  end

  always_comb begin
    case (s_r.ctrl.mode)
      srxal_pkg::AM_SLIP: hit = s_r.ctrl.w10 ? hit10 : (hist_new[31:24] == s_r.pat[7:0]);
      srxal_pkg::AM_16:   hit = hit16;
      default:            hit = hit10;
    endcase
  end

  // Illegal mode and protocol pairs disable alignment and report in status
  always_comb begin
    case (s_r.ctrl.mode)
      srxal_pkg::AM_SLIP: mode_ok = (s_r.ctrl.proto == srxal_pkg::PR_CUSTOM) ||
                                    (s_r.ctrl.proto == srxal_pkg::PR_SONET); // [R13] [R11]
      srxal_pkg::AM_16:   mode_ok = !s_r.ctrl.w10 && // [R16]
                                    ((s_r.ctrl.proto == srxal_pkg::PR_SONET) ||
                                     (s_r.ctrl.proto == srxal_pkg::PR_CUSTOM &&
                                      !s_r.ctrl.fmt4)); // [R17]
      srxal_pkg::AM_10:   mode_ok = s_r.ctrl.w10 && (s_r.ctrl.proto == srxal_pkg::PR_CUSTOM);
      srxal_pkg::AM_XAUI: mode_ok = s_r.ctrl.w10 && s_r.ctrl.proto == srxal_pkg::PR_XAUI; // [R21]
      srxal_pkg::AM_GIGE: mode_ok = s_r.ctrl.w10 && s_r.ctrl.proto == srxal_pkg::PR_GIGE; // [R21]
      default:            mode_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (s_r.ctrl.mode)
      srxal_pkg::AM_16:   allow = !s_r.aligned || s_r.realign_pend; // [R15]
      srxal_pkg::AM_10:   allow = s_r.ctrl.align_en; // [R20]
      srxal_pkg::AM_XAUI: allow = (s_r.sync == srxal_pkg::SY_LOSS);
      srxal_pkg::AM_GIGE: allow = (s_r.sync == srxal_pkg::SY_LOSS);
      default:            allow = 1'b0; // [R12]
    endcase
  end

  assign take_align = bit_v && mode_ok && hit && allow;
  // A pending slip stretches one word by a bit, moving the boundary once
  assign hold = s_r.slip_pend && mode_ok && (s_r.ctrl.mode == srxal_pkg::AM_SLIP); // [R10]

  // Run limit in units of 5 or 4 bits, step clamped to 1..32
  assign stp = (s_r.ctrl.run_step == 6'h00) ? 6'h01 :
               ((s_r.ctrl.run_step > srxal_pkg::RL_STEPMX) ? srxal_pkg::RL_STEPMX
                                                           : s_r.ctrl.run_step);
  assign rl_limit = 8'({2'b00, stp} * (s_r.ctrl.w10 ? srxal_pkg::RL_UNIT10 : srxal_pkg::RL_UNIT8)); // [R22]

  assign ppm_thr = srxal_pkg::PPM_BASE << s_r.ctrl.ppm_sel; // [R3]

  // ==========================================================================
  // APB decode
  assign setup    = PSEL && !PENABLE;
  assign access   = PSEL && PENABLE && s_r.pready;
  assign unmapped = (PADDR[1:0] != 2'b00) ||
                    !((PADDR == srxal_pkg::OFS_CTRL) || (PADDR == srxal_pkg::OFS_PAT) ||
                      (PADDR == srxal_pkg::OFS_STAT) || (PADDR == srxal_pkg::OFS_DATA));

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      srxal_pkg::OFS_CTRL: rd_mux = s_r.ctrl;
      srxal_pkg::OFS_PAT:  rd_mux = {12'h000, s_r.pat};
      srxal_pkg::OFS_STAT: begin
        rd_mux[srxal_pkg::ST_FLOCK] = s_r.lock_data;
        rd_mux[srxal_pkg::ST_PLOCK] = !s_r.plock_n;
        rd_mux[srxal_pkg::ST_ALIGN] = s_r.aligned;
        rd_mux[srxal_pkg::ST_PAT]   = s_r.pat_st;
        rd_mux[srxal_pkg::ST_RLV]   = s_r.rlv_st;
        rd_mux[srxal_pkg::ST_MERR]  = !mode_ok;
      end
      srxal_pkg::OFS_DATA: rd_mux = {12'h000, s_r.dout};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.dvalid = 1'b0;
    s_nxt.patdet = 1'b0;

    // APB: answer is registered at setup, so access lasts one cycle
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && unmapped;
    if (setup) begin
      s_nxt.prdata = unmapped ? 32'h0000_0000 : rd_mux;
    end
    if (access && PWRITE && !s_r.pslverr) begin
      case (PADDR)
        srxal_pkg::OFS_CTRL: begin
          s_nxt.ctrl = srxal_pkg::srxal_ctrl_t'(PWDATA);
          s_nxt.ctrl.rsvd = 9'h000;
          s_nxt.ctrl.realign = 1'b0;
          if (PWDATA[15]) begin
            s_nxt.realign_pend = 1'b1; // [R15]
          end
        end
        srxal_pkg::OFS_PAT: s_nxt.pat = PWDATA[19:0];
        srxal_pkg::OFS_STAT: begin
          // Clears come first so a same-cycle event below still sets
          if (PWDATA[srxal_pkg::ST_PAT]) begin
            s_nxt.pat_st = 1'b0;
          end
          if (PWDATA[srxal_pkg::ST_RLV]) begin
            s_nxt.rlv_st = 1'b0;
          end
        end
        default: s_nxt.pat = s_r.pat;
      endcase
    end

    // Lock source and power
    s_nxt.pwr_dn  = !s_r.ctrl.chan_en; // [R7]
    s_nxt.plock_n = !(PLL_REF_LOCK && s_r.ctrl.chan_en); // [R6]
    if (!s_r.ctrl.chan_en) begin
      s_nxt.lock_data = 1'b0; // [R7]
    end else if (s_r.ctrl.force_data) begin
      s_nxt.lock_data = 1'b1; // [R1]
    end else if (s_r.ctrl.force_ref) begin
      s_nxt.lock_data = 1'b0; // [R1]
    end else begin
      // Automatic: enter on frequency and phase, drop back on frequency loss
      s_nxt.lock_data = (CRU_PPM_ERR <= ppm_thr) && // [R2] [R3]
                        (s_r.lock_data || (CRU_PHASE_ERR <= srxal_pkg::PHASE_LIM)); // [R4]
    end

    // Slip request edge
    s_nxt.slip_prev = s_r.ctrl.slip;
    if (s_r.ctrl.slip && !s_r.slip_prev) begin
      s_nxt.slip_pend = 1'b1; // [R24]
    end

    if (bit_v) begin
      s_nxt.hist = hist_new;

      // Boundary counter
      if (take_align || (on_bnd && !hold)) begin
        s_nxt.bcnt = 4'h0;
      end else if (hold) begin
        s_nxt.bcnt = s_r.bcnt;
        s_nxt.slip_pend = 1'b0; // [R10]
      end else begin
        s_nxt.bcnt = s_r.bcnt + 4'h1;
      end

      // Word emission, pairs for double width, first word low
      if (take_align) begin
        s_nxt.half = s_r.ctrl.dbl;
        s_nxt.lo_word = word;
        if (!s_r.ctrl.dbl) begin
          s_nxt.dout = {10'h000, word};
          s_nxt.dvalid = 1'b1;
        end
      end else if (on_bnd && !hold) begin
        if (!s_r.ctrl.dbl) begin
          s_nxt.dout = {10'h000, word};
          s_nxt.dvalid = 1'b1;
        end else if (!s_r.half) begin
          s_nxt.lo_word = word;
          s_nxt.half = 1'b1;
        end else begin
          s_nxt.dout = s_r.ctrl.w10 ? {word, s_r.lo_word}
                                    : {4'h0, word[7:0], s_r.lo_word[7:0]}; // [R11]
          s_nxt.dvalid = 1'b1;
          s_nxt.half = 1'b0;
        end
      end

      // Pattern detector runs in every legal mode
      if (hit && mode_ok) begin
        s_nxt.patdet = 1'b1; // [R12]
        s_nxt.pat_st = 1'b1;
      end

      // Alignment status
      case (s_r.ctrl.mode)
        srxal_pkg::AM_16, srxal_pkg::AM_10: begin
          if (take_align) begin
            s_nxt.aligned = 1'b1; // [R14] [R18]
            s_nxt.realign_pend = 1'b0;
          end
        end
        srxal_pkg::AM_XAUI, srxal_pkg::AM_GIGE: begin
          // Three boundary commas acquire, four stray commas lose sync
          if (mode_ok && hit) begin
            if (take_align) begin
              s_nxt.sync = srxal_pkg::SY_DET1; // [R21]
              s_nxt.miss = 3'h0;
            end else if (on_bnd) begin
              case (s_r.sync)
                srxal_pkg::SY_DET1: s_nxt.sync = srxal_pkg::SY_DET2;
                srxal_pkg::SY_DET2: s_nxt.sync = srxal_pkg::SY_SYNC;
                default:            s_nxt.miss = 3'h0;
              endcase
            end else if (s_r.sync == srxal_pkg::SY_SYNC) begin
              s_nxt.miss = s_r.miss + 3'h1;
              if (s_r.miss + 3'h1 == srxal_pkg::LOSE_CNT) begin
                s_nxt.sync = srxal_pkg::SY_LOSS;
              end
            end else begin
              s_nxt.sync = srxal_pkg::SY_LOSS;
            end
          end
          s_nxt.aligned = (s_nxt.sync == srxal_pkg::SY_SYNC);
        end
        default: s_nxt.aligned = 1'b0;
      endcase

      // Run length
      if (SER_IN == s_r.run_bit) begin
        if (s_r.run_len != 8'hFF) begin
          s_nxt.run_len = s_r.run_len + 8'h01;
        end
        if (s_r.run_len == rl_limit) begin
          s_nxt.rlv_st = 1'b1; // [R23]
        end
      end else begin
        s_nxt.run_bit = SER_IN;
        s_nxt.run_len = 8'h01;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_r         <= '0;
      s_r.ctrl    <= srxal_pkg::srxal_ctrl_t'(srxal_pkg::CTRL_RST); // [R2]
      s_r.sync    <= srxal_pkg::SY_LOSS;
      s_r.plock_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA         = s_r.prdata;
  assign PREADY         = s_r.pready;
  assign PSLVERR        = s_r.pslverr;
  assign DATA_OUT       = s_r.dout;
  assign DATA_VALID     = s_r.dvalid;
  assign ALIGNED        = s_r.aligned;
  assign PATTERN_DET    = s_r.patdet;
  assign RUN_VIOL       = s_r.rlv_st;
  assign FREQ_LOCKED    = s_r.lock_data; // [R5]
  assign RX_LOCKED_N    = s_r.plock_n;
  assign CRU_PWR_DN     = s_r.pwr_dn;
  assign CRU_TRAIN_DATA = s_r.lock_data;

endmodule

// ===== hdl/srxal_pkg.sv
// Constants, types and register layout of the receive lock and word-align block
// How it works
// [R1] Force-data selects data lock; else force-reference selects reference; else automatic
// [R2] Both override bits reset to zero, so an untouched lane runs automatic
// [R3] Automatic move to data lock needs frequency within 125/250/500/1000 PPM threshold
// [R4] Automatic move to data lock also needs phase error within 0.08 UI
// [R5] Frequency-locked output shows the recovery unit is locked to data
// [R6] Active-low lock output reports receiver PLL locked to its reference
// [R7] Disabled channel powers down its PLL and clock recovery unit
// [R8] Deserializer builds 8- or 10-bit words from the serial stream
// [R9] First received bit of a word lands in its least significant bit
// [R10] Each slip request moves the word boundary by exactly one bit
// [R11] Bit-slip works on 8- and 10-bit paths, single or double width
// [R12] Pattern detector keeps flagging in bit-slip mode without moving boundary
// [R13] Bit-slip mode only legal with custom or SONET protocol
// [R14] 16-bit mode aligns to a 16-bit pattern as A1A2 or A1A1A2A2
// [R15] Software may request re-alignment in 16-bit mode; device then re-aligns
// [R16] 16-bit mode runs only on the 8-bit path, single or double width
// [R17] 16-bit mode custom or SONET only; A1A1A2A2 only with SONET
// [R18] 10-bit mode aligns to preset pattern, all ten or lowest seven bits
// [R19] 10-bit pattern recognised in both disparities
// [R20] 10-bit mode aligns only while the aligner enable bit is set
// [R21] XAUI and GIGE modes align to K28.5 with a sync machine, own protocol only
// [R22] Run length limit 5..160 step 5 on 10-bit, 4..128 step 4 on 8-bit
// [R23] Run-length violation flag when identical bits exceed the limit
// [R24] Slip request is edge-detected so a held request shifts only once
package srxal_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PAT  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;

  localparam int ST_FLOCK = 0;
  localparam int ST_PLOCK = 1;
  localparam int ST_ALIGN = 2;
  localparam int ST_PAT   = 3;
  localparam int ST_RLV   = 4;
  localparam int ST_MERR  = 5;

  // ==========================================================================
  // Modes
  typedef enum logic [2:0] {AM_SLIP, AM_16, AM_10, AM_XAUI, AM_GIGE} srxal_mode_t;
  typedef enum logic [1:0] {PR_CUSTOM, PR_SONET, PR_XAUI, PR_GIGE} srxal_proto_t;
  typedef enum logic [1:0] {SY_LOSS, SY_DET1, SY_DET2, SY_SYNC} srxal_sync_t;

  typedef struct packed {
    logic [8:0]   rsvd;
    logic [5:0]   run_step;
    logic         slip;
    logic         realign;
    logic         align_en;
    logic         match7;
    logic         fmt4;
    srxal_proto_t proto;
    srxal_mode_t  mode;
    logic         dbl;
    logic         w10;
    logic [1:0]   ppm_sel;
    logic         force_data;
    logic         force_ref;
    logic         chan_en;
  } srxal_ctrl_t;

  // Channel enabled, run step 1, automatic lock, custom bit-slip 8-bit
  localparam logic [31:0] CTRL_RST = 32'h0002_0001;

  // ==========================================================================
  // Numbers
  localparam logic [9:0]  K28_RDN   = 10'h17C;
  localparam logic [9:0]  K28_RDP   = 10'h283;
  localparam logic [10:0] PPM_BASE  = 11'h07D;
  localparam logic [7:0]  PHASE_LIM = 8'h08;
  localparam logic [3:0]  RL_UNIT10 = 4'h5;
  localparam logic [3:0]  RL_UNIT8  = 4'h4;
  localparam logic [5:0]  RL_STEPMX = 6'h20;
  localparam logic [2:0]  LOSE_CNT  = 3'h4;

  // ==========================================================================
  // Whole block state
  typedef struct packed {
    srxal_ctrl_t ctrl;
    logic [19:0] pat;
    logic        lock_data;
    logic        plock_n;
    logic        pwr_dn;
    logic [31:0] hist;
    logic [3:0]  bcnt;
    logic        slip_prev;
    logic        slip_pend;
    logic        realign_pend;
    logic        aligned;
    srxal_sync_t sync;
    logic [2:0]  miss;
    logic        run_bit;
    logic [7:0]  run_len;
    logic        pat_st;
    logic        rlv_st;
    logic        half;
    logic [9:0]  lo_word;
    logic [19:0] dout;
    logic        dvalid;
    logic        patdet;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } srxal_st_t;

endpackage

// ===== testbench/srxal_tx_model.sv
// Remote serial transmitter model driving the recovered bit lane
`timescale 1ns/1ns
module srxal_tx_model (
  input  wire logic clk,   // Bit clock, same as system clock
  output logic      ser,   // Serial bit
  output logic      valid  // Bit present this cycle
);
  initial begin
    ser = 1'b0;
    valid = 1'b0;
  end

  // ====================
  // Word sender
  // Idle line shows the inverse of the last bit, so a stale bit never passes as data
  task automatic send(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      valid <= 1'b1;
      ser <= v[i];
    end
    @(posedge clk);
    valid <= 1'b0;
    ser <= ~v[n-1];
  endtask
endmodule

// ===== testbench/srxal_assertions.sv
// Port-level checks bound onto the receive lock and word-align block
`timescale 1ns/1ns
module srxal_assertions (
  input wire logic SYS_CLK,        // Clock
  input wire logic SYS_RST,        // Reset
  input wire logic PSEL,           // Select
  input wire logic PENABLE,        // Enable
  input wire logic PREADY,         // Ready
  input wire logic PSLVERR,        // Error
  input wire logic SER_VALID,      // Bit present
  input wire logic PLL_REF_LOCK,   // PLL lock in
  input wire logic DATA_VALID,     // Word strobe
  input wire logic ALIGNED,        // Aligned
  input wire logic PATTERN_DET,    // Pattern pulse
  input wire logic RUN_VIOL,       // Run flag
  input wire logic FREQ_LOCKED,    // Data lock
  input wire logic RX_LOCKED_N,    // PLL lock out
  input wire logic CRU_PWR_DN,     // Power-down
  input wire logic CRU_TRAIN_DATA  // Training source
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ====================
  // Register bus
  setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("PREADY missing after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("PREADY longer than one cycle");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("PSLVERR without PREADY");
  reset_values_a: assert property (disable iff (1'b0)
    SYS_RST |=> RX_LOCKED_N && !PREADY && !DATA_VALID && !FREQ_LOCKED && !RUN_VIOL)
    else $error("Outputs not at reset values");

  // ====================
  // Lock and data path
  train_match_a: assert property (CRU_TRAIN_DATA == FREQ_LOCKED)
    else $error("Training source differs from lock flag");
  lock_n_src_a: assert property (!RX_LOCKED_N |-> $past(PLL_REF_LOCK))
    else $error("Lock output low without PLL lock");
  pwr_dn_lock_a: assert property (CRU_PWR_DN [*2] |-> !FREQ_LOCKED)
    else $error("Data lock while powered down");
  word_after_bit_a: assert property (DATA_VALID |-> $past(SER_VALID))
    else $error("Word strobe without a received bit");
  pat_after_bit_a: assert property (PATTERN_DET |-> $past(SER_VALID))
    else $error("Pattern pulse without a received bit");
  run_set_a: assert property ($rose(RUN_VIOL) |-> $past(SER_VALID))
    else $error("Run flag set without a received bit");
  // Two idle bus cycles, since a status clear may land one cycle late
  run_hold_a: assert property (RUN_VIOL && !PSEL && !$past(PSEL) |=> RUN_VIOL)
    else $error("Run flag dropped without a clear");
  cover property ($rose(FREQ_LOCKED));
  cover property ($rose(ALIGNED));
  cover property ($rose(RUN_VIOL));
  cover property (PSLVERR);
endmodule

bind srxal_top srxal_assertions i_srxal_assertions (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SER_VALID(SER_VALID), .PLL_REF_LOCK(PLL_REF_LOCK),
  .DATA_VALID(DATA_VALID), .ALIGNED(ALIGNED), .PATTERN_DET(PATTERN_DET), .RUN_VIOL(RUN_VIOL),
  .FREQ_LOCKED(FREQ_LOCKED), .RX_LOCKED_N(RX_LOCKED_N), .CRU_PWR_DN(CRU_PWR_DN),
  .CRU_TRAIN_DATA(CRU_TRAIN_DATA)
);

// ===== testbench/tb_srxal_top.sv
// Self-checking bench for the receive lock and word-align block
`timescale 1ns/1ns
module tb_srxal_top;
  logic        SYS_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic        PLL_REF_LOCK = 1'b0;
  logic [10:0] CRU_PPM_ERR = 11'h7FF;
  logic [7:0]  CRU_PHASE_ERR = 8'hFF;
  logic [31:0] PRDATA;
  logic [19:0] DATA_OUT;
  logic        PREADY, PSLVERR, SER_IN, SER_VALID, DATA_VALID, ALIGNED;
  logic        PATTERN_DET, RUN_VIOL, FREQ_LOCKED, RX_LOCKED_N, CRU_PWR_DN, CRU_TRAIN_DATA;
  int          bad_count = 0;
  int          compares = 0;
  int          seed = 35;
  int          pd_cnt = 0;
  int          nb;
  logic [19:0] rxq [$];
  logic [31:0] rd, v;
  logic [31:0] bad_cfg [5];
  logic [10:0] thr;
  logic        er;

  srxal_top i_srxal_top (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SER_IN(SER_IN), .SER_VALID(SER_VALID), .PLL_REF_LOCK(PLL_REF_LOCK),
    .CRU_PPM_ERR(CRU_PPM_ERR), .CRU_PHASE_ERR(CRU_PHASE_ERR), .DATA_OUT(DATA_OUT),
    .DATA_VALID(DATA_VALID), .ALIGNED(ALIGNED), .PATTERN_DET(PATTERN_DET),
    .RUN_VIOL(RUN_VIOL), .FREQ_LOCKED(FREQ_LOCKED), .RX_LOCKED_N(RX_LOCKED_N),
    .CRU_PWR_DN(CRU_PWR_DN), .CRU_TRAIN_DATA(CRU_TRAIN_DATA)
  );
  srxal_tx_model i_srxal_tx_model (.clk(SYS_CLK), .ser(SER_IN), .valid(SER_VALID));

  // ====================
  // Clock, monitor, tasks
  initial forever #10 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (DATA_VALID === 1'b1) rxq.push_back(DATA_OUT);
    if (PATTERN_DET === 1'b1) pd_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rst();
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rxq.delete();
    pd_cnt = 0;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic lk(input logic [10:0] p, input logic [7:0] ph, input logic e);
    @(posedge SYS_CLK);
    CRU_PPM_ERR <= p;
    CRU_PHASE_ERR <= ph;
    repeat (6) @(posedge SYS_CLK);
    chk("freq locked", e, FREQ_LOCKED);
    chk("train data", e, CRU_TRAIN_DATA);
  endtask
  // Sends pattern p reps times between alternating filler; x inverts every other copy
  task automatic al(input logic [31:0] c, input logic [15:0] pw, input logic [31:0] p,
                    input int n, input int reps, input logic x, input logic ex);
    logic [31:0] q;
    int          f;
    f = 0;
    rst();
    apb(1'b1, 8'h04, {16'h0000, pw});
    apb(1'b1, 8'h00, c);
    i_srxal_tx_model.send(32'h0000_0005, 3);
    q = x ? ~p : p;
    for (int r = 0; r < reps; r++) begin
      i_srxal_tx_model.send(q, n);
      i_srxal_tx_model.send(32'h5555_5555, n);
      q = x ? ~q : q;
    end
    repeat (3) @(posedge SYS_CLK);
    chk("aligned", ex, ALIGNED);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("mode error", 0, rd[5]);
    foreach (rxq[k]) f += (rxq[k][9:0] === p[9:0] || rxq[k][9:0] === ~p[9:0]);
    if (n == 10 && ex) chk("hit word", 1, f > 0);
  endtask

  // ====================
  // Scenarios
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    bad_cfg = '{32'h0002_0801, 32'h0002_1081, 32'h0002_00A1, 32'h0002_0521, 32'h0002_0DA1};
    rst();
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", 32'h0002_0001, rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 1, er);
    apb(1'b0, 8'h06, 32'h0000_0000);
    chk("misaligned err", 1, er);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, 32'h0002_0001 | (32'(i[1:0]) << 1));
      lk(i[2] ? 11'h064 : 11'h7D0, i[2] ? 8'h05 : 8'h32, i[1] | (i[2] & ~i[0]));
    end
    for (int s = 0; s < 4; s++) begin
      thr = 11'h07D << s;
      apb(1'b1, 8'h00, 32'h0002_0001 | (32'(s) << 3));
      lk(thr + 11'h001, 8'h00, 1'b0);
      lk(thr, 8'h09, 1'b0);
      lk(thr, 8'h08, 1'b1);
      lk(thr + 11'h001, 8'h00, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge SYS_CLK);
      PLL_REF_LOCK <= j[0];
      repeat (3) @(posedge SYS_CLK);
      chk("locked_n", !j[0], RX_LOCKED_N);
    end
    rst();
    apb(1'b1, 8'h00, 32'h0002_0004);
    lk(11'h064, 8'h00, 1'b0);
    chk("power down", 1, CRU_PWR_DN);
    chk("locked_n off", 1, RX_LOCKED_N);
    i_srxal_tx_model.send($random(seed), 8);
    repeat (3) @(posedge SYS_CLK);
    chk("words while off", 0, rxq.size());
    for (int c = 0; c < 4; c++) begin
      rst();
      nb = (c[0] ? 10 : 8) * (c[1] + 1);
      apb(1'b1, 8'h00, 32'h0002_0001 | (32'(c) << 5));
      for (int k = 0; k < 2; k++) begin
        v = $random(seed);
        i_srxal_tx_model.send(v, nb);
        repeat (2) @(posedge SYS_CLK);
        chk("word", v & ((32'h0000_0001 << nb) - 1), 32'(rxq.pop_front()));
      end
    end
    rst();
    v = $random(seed);
    apb(1'b1, 8'h04, {24'h00_0000, v[16:9]});
    apb(1'b1, 8'h00, 32'h0003_0001);
    apb(1'b1, 8'h00, 32'h0003_0001);
    i_srxal_tx_model.send(v, 32);
    repeat (2) @(posedge SYS_CLK);
    chk("slipped word", v[16:9], 32'(rxq[1]));
    chk("pattern pulse", 1, pd_cnt > 0);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("pattern sticky", 1, rd[3]);
    al(32'h0002_4121, 16'h02FC, 32'h0000_02FC, 10, 1, 1'b1, 1'b1);
    al(32'h0002_0121, 16'h02FC, 32'h0000_02FC, 10, 1, 1'b1, 1'b0);
    al(32'h0002_6121, 16'h017C, 32'h0000_02FC, 10, 1, 1'b0, 1'b1);
    al(32'h0002_0081, 16'h28F6, 32'h0000_28F6, 16, 1, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h0002_8081);
    rxq.delete();
    i_srxal_tx_model.send(32'h0000_51EC, 17);
    repeat (2) @(posedge SYS_CLK);
    chk("realign word", 32'h0000_0028, 32'(rxq[$]));
    al(32'h0002_1481, 16'h28F6, 32'h2828_F6F6, 32, 1, 1'b0, 1'b1);
    al(32'h0002_09A1, 16'h0000, 32'h0000_017C, 10, 3, 1'b1, 1'b1);
    al(32'h0002_0E21, 16'h0000, 32'h0000_017C, 10, 3, 1'b1, 1'b1);
    foreach (bad_cfg[j]) begin
      apb(1'b1, 8'h00, bad_cfg[j]);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("illegal mode", 1, rd[5]);
    end
    for (int w = 0; w < 2; w++) begin
      rst();
      apb(1'b1, 8'h00, 32'h0004_0001 | (32'(w) << 5));
      i_srxal_tx_model.send(32'h0000_0001, 1);
      i_srxal_tx_model.send(32'h0000_0000, w ? 10 : 8);
      repeat (3) @(posedge SYS_CLK);
      chk("run at limit", 0, RUN_VIOL);
      i_srxal_tx_model.send(32'h0000_0000, 1);
      repeat (3) @(posedge SYS_CLK);
      chk("run over limit", 1, RUN_VIOL);
      apb(1'b1, 8'h08, 32'h0000_0010);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("run cleared", 0, rd[4]);
    end
    conclude();
  end
endmodule
